//--- port_phy_pkg.sv
// Package with register map, field layout, reset values and rate codes for the port PHY register bank.
// Function
// - Egress rate word bits 14-8 hold a writable priority 3 limit, reset zero.
// - Egress rate word bits 6-0 hold a writable priority 2 limit, reset zero.
// - At 100 Mbps codes 1 to 100 mean 1 to 100 Mbps; zero means no limit.
// - At 10 Mbps codes 1 to 10 are Mbps; codes 101 to 115 step 64 kbps.
// - A read-only flag shows a detected short closer than ten meters.
// - A 2-bit read-only outcome: normal, open, short, or test failed.
// - Writing one to the start bit runs a cable test; it clears when done.
// - Fault distance is a 9-bit read-only count of about 0.4 meter each.
// - The force-link bit forces link pass; zero keeps normal link detection.
// - The remote loopback bit loops receive pair to transmit pair in the PHY.
// - The transmit-disable bit turns the port transmitter off.
// - Writing one to negotiation-restart restarts negotiation; the bit clears itself.
// - The power-down bit powers the PHY down and keeps all register settings.
// - The crossover-auto-disable bit turns automatic MDI/MDI-X selection off.
// - Force-crossover forces MDI-X only while automatic crossover is disabled.
// - Far-end loopback loops the other port's traffic at this port's PMD/PMA.
// - Negotiation is on after reset; when off, speed and duplex come from force bits.
// - With negotiation off, force-speed one means 100 Mbps, zero 10 Mbps; reset one.
// - Force-duplex picks full or half when negotiation is off or has failed.
// - Five advertisement bits, reset one, offer pause and the four speed modes.
package port_phy_pkg;
  localparam logic [11:0] ADDR_EGRESS = 12'h07A;
  localparam logic [11:0] ADDR_CABLE = 12'h07C;
  localparam logic [11:0] ADDR_CTRL4 = 12'h07E;

  localparam logic [15:0] EGRESS_RST = 16'h0000;
  localparam logic [15:0] CTRL4_RST = 16'h00FF;
  localparam logic CABLE_RSV10_RST = 1'b1;

  // Cable diagnostic word fields.
  localparam int CAB_SHORT = 15;
  localparam int CAB_OUT_HI = 14;
  localparam int CAB_OUT_LO = 13;
  localparam int CAB_START = 12;
  localparam int CAB_FLINK = 11;
  localparam int CAB_RSV10 = 10;
  localparam int CAB_RLOOP = 9;

  // Control word four fields.
  localparam int C4_TXDIS = 14;
  localparam int C4_ANRST = 13;
  localparam int C4_RSV12 = 12;
  localparam int C4_PWRDN = 11;
  localparam int C4_MDIXDIS = 10;
  localparam int C4_FMDIX = 9;
  localparam int C4_FARLOOP = 8;
  localparam int C4_ANEN = 7;
  localparam int C4_FSPD = 6;
  localparam int C4_FDUP = 5;
  localparam int C4_ADV_HI = 4;

  // Alias view selectors for the PHY-side register port.
  localparam logic [1:0] VIEW_BASIC = 2'h0;
  localparam logic [1:0] VIEW_ADV = 2'h1;
  localparam logic [1:0] VIEW_PHYCTRL = 2'h2;

  // Alias view bit positions.
  localparam int BAS_FARLOOP = 14;
  localparam int BAS_FSPD = 13;
  localparam int BAS_ANEN = 12;
  localparam int BAS_PWRDN = 11;
  localparam int BAS_ANRST = 9;
  localparam int BAS_FDUP = 8;
  localparam int BAS_FMDIX = 4;
  localparam int BAS_MDIXDIS = 3;
  localparam int BAS_RSV = 2;
  localparam int BAS_TXDIS = 1;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_LO = 5;
  localparam int PCT_FLINK = 3;
  localparam int PCT_RLOOP = 1;

  // Rate limit codes and scaling in kbps.
  localparam logic [6:0] CODE_MAX_100 = 7'h64;
  localparam logic [6:0] CODE_MAX_10 = 7'h0A;
  localparam logic [6:0] CODE_SUB_LO = 7'h65;
  localparam logic [6:0] CODE_SUB_HI = 7'h73;
  localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;
  localparam logic [16:0] SUB_STEP_KBPS = 17'h00040;

  typedef enum logic [0:0] {CDT_IDLE, CDT_RUN} cdt_state_t;
endpackage : port_phy_pkg

//--- rate_code_decode.sv
// Decoder from a 7-bit rate limit code to a limit in kbps for the egress shaper.
`timescale 1ns/10ps
`default_nettype none
module rate_code_decode (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] code,
  input wire logic speed_100,
  output logic [16:0] rate_kbps,
  output logic unlimited
);
  typedef struct packed {
    logic [16:0] rate;
    logic unl;
  } dec_t;

  dec_t q_ff;
  dec_t nxt_q;
  logic [6:0] max_code;
  logic [6:0] sub_idx;

  always_comb
  begin
    nxt_q = q_ff;
    max_code = speed_100 ? port_phy_pkg::CODE_MAX_100 : port_phy_pkg::CODE_MAX_10;
    sub_idx = code - port_phy_pkg::CODE_MAX_100;
    if (code == 7'h00)
    begin
      nxt_q.unl = 1'b1;
      nxt_q.rate = 17'h00000;
    end
    else if (code <= max_code)
    begin
      nxt_q.unl = 1'b0;
      nxt_q.rate = 17'(code) * port_phy_pkg::KBPS_PER_MBPS;
    end
    else if (code >= port_phy_pkg::CODE_SUB_LO && code <= port_phy_pkg::CODE_SUB_HI)
    begin
      nxt_q.unl = 1'b0;
      nxt_q.rate = 17'(sub_idx) * port_phy_pkg::SUB_STEP_KBPS;
    end
    else
    begin
      // Codes above the line rate or the table leave the port at full rate.
      nxt_q.unl = 1'b1;
      nxt_q.rate = 17'h00000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q_ff <= '{rate: 17'h00000, unl: 1'b1};
    else
      q_ff <= nxt_q;
  end

  assign rate_kbps = q_ff.rate;
  assign unlimited = q_ff.unl;

  AST_MBPS_CODE: assert property (@(posedge clk) disable iff (sys_rst)
    (speed_100 && code != 7'h00 && code <= 7'h64)
    |=> (rate_kbps == 17'($past(code)) * 17'd1000 && !unlimited))
    else $error("Mbps rate code decoded wrongly.");

  AST_SUB_CODE: assert property (@(posedge clk) disable iff (sys_rst)
    (code >= 7'h65 && code <= 7'h73)
    |=> (rate_kbps == 17'($past(code) - 7'h64) * 17'd64 && !unlimited))
    else $error("Sub-megabit rate code decoded wrongly.");
endmodule : rate_code_decode
`default_nettype wire

//--- port_phy_control_regs.sv
// Register bank for egress rate, cable diagnostics and PHY control of one switch port.
`timescale 1ns/10ps
`default_nettype none
module port_phy_control_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic view_wr,
  input wire logic [1:0] view_sel,
  input wire logic [15:0] view_wdata,
  output logic [15:0] basic_view,
  output logic [15:0] adv_view,
  output logic [15:0] phyctrl_view,
  output logic cdt_req,
  input wire logic cdt_done,
  input wire logic [1:0] cdt_outcome_in,
  input wire logic cdt_short_in,
  input wire logic [8:0] cdt_count_in,
  output logic force_link,
  output logic remote_loop,
  output logic tx_disable,
  output logic an_restart,
  output logic power_down,
  output logic mdix_auto_disable,
  output logic force_mdix,
  output logic far_end_loop,
  output logic an_enable,
  output logic [4:0] adv_caps,
  input wire logic an_good,
  input wire logic an_speed_100,
  input wire logic an_full_dup,
  output logic link_speed_100,
  output logic link_full_dup,
  output logic [16:0] prio3_rate_kbps,
  output logic prio3_unlimited,
  output logic [16:0] prio2_rate_kbps,
  output logic prio2_unlimited
);
  typedef struct packed {
    logic [15:0] egress;
    port_phy_pkg::cdt_state_t cdt;
    logic near_short;
    logic [1:0] outcome;
    logic [8:0] fault;
    logic flink;
    logic rsv10;
    logic rloop;
    logic [15:0] ctrl4;
    logic an_pulse;
    logic spd100;
    logic fdup;
    logic [15:0] rdata;
  } bank_t;

  bank_t q_ff;
  bank_t nxt_q;
  logic [15:0] cable_word;
  logic [15:0] merged;

  // Cable diagnostic word as software sees it.
  always_comb
  begin
    cable_word = 16'h0000;
    cable_word[port_phy_pkg::CAB_SHORT] = q_ff.near_short;
    cable_word[port_phy_pkg::CAB_OUT_HI:port_phy_pkg::CAB_OUT_LO] = q_ff.outcome;
    cable_word[port_phy_pkg::CAB_START] = (q_ff.cdt == port_phy_pkg::CDT_RUN);
    cable_word[port_phy_pkg::CAB_FLINK] = q_ff.flink;
    cable_word[port_phy_pkg::CAB_RSV10] = q_ff.rsv10;
    cable_word[port_phy_pkg::CAB_RLOOP] = q_ff.rloop;
    cable_word[8:0] = q_ff.fault;
  end

  // Basic and advertisement alias views are built from the same flops as control word four; the PHY-control view from the cable word's.
  always_comb
  begin
    basic_view = 16'h0000;
    basic_view[port_phy_pkg::BAS_FARLOOP] = q_ff.ctrl4[port_phy_pkg::C4_FARLOOP];
    basic_view[port_phy_pkg::BAS_FSPD] = q_ff.ctrl4[port_phy_pkg::C4_FSPD];
    basic_view[port_phy_pkg::BAS_ANEN] = q_ff.ctrl4[port_phy_pkg::C4_ANEN];
    basic_view[port_phy_pkg::BAS_PWRDN] = q_ff.ctrl4[port_phy_pkg::C4_PWRDN];
    basic_view[port_phy_pkg::BAS_ANRST] = q_ff.ctrl4[port_phy_pkg::C4_ANRST];
    basic_view[port_phy_pkg::BAS_FDUP] = q_ff.ctrl4[port_phy_pkg::C4_FDUP];
    basic_view[port_phy_pkg::BAS_FMDIX] = q_ff.ctrl4[port_phy_pkg::C4_FMDIX];
    basic_view[port_phy_pkg::BAS_MDIXDIS] = q_ff.ctrl4[port_phy_pkg::C4_MDIXDIS];
    basic_view[port_phy_pkg::BAS_RSV] = q_ff.ctrl4[port_phy_pkg::C4_RSV12];
    basic_view[port_phy_pkg::BAS_TXDIS] = q_ff.ctrl4[port_phy_pkg::C4_TXDIS];
    adv_view = 16'h0000;
    adv_view[port_phy_pkg::ADV_PAUSE] = q_ff.ctrl4[port_phy_pkg::C4_ADV_HI];
    adv_view[port_phy_pkg::ADV_LO + 3:port_phy_pkg::ADV_LO] = q_ff.ctrl4[3:0];
    phyctrl_view = 16'h0000;
    phyctrl_view[port_phy_pkg::PCT_FLINK] = q_ff.flink;
    phyctrl_view[port_phy_pkg::PCT_RLOOP] = q_ff.rloop;
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.an_pulse = 1'b0;
    merged = 16'h0000;

    // Writes through the alias views land in the shared storage.
    if (view_wr)
    begin
      unique case (view_sel)
        port_phy_pkg::VIEW_BASIC:
        begin
          nxt_q.ctrl4[port_phy_pkg::C4_FARLOOP] = view_wdata[port_phy_pkg::BAS_FARLOOP];
          nxt_q.ctrl4[port_phy_pkg::C4_FSPD] = view_wdata[port_phy_pkg::BAS_FSPD];
          nxt_q.ctrl4[port_phy_pkg::C4_ANEN] = view_wdata[port_phy_pkg::BAS_ANEN];
          nxt_q.ctrl4[port_phy_pkg::C4_PWRDN] = view_wdata[port_phy_pkg::BAS_PWRDN];
          nxt_q.ctrl4[port_phy_pkg::C4_FDUP] = view_wdata[port_phy_pkg::BAS_FDUP];
          nxt_q.ctrl4[port_phy_pkg::C4_FMDIX] = view_wdata[port_phy_pkg::BAS_FMDIX];
          nxt_q.ctrl4[port_phy_pkg::C4_MDIXDIS] = view_wdata[port_phy_pkg::BAS_MDIXDIS];
          nxt_q.ctrl4[port_phy_pkg::C4_RSV12] = view_wdata[port_phy_pkg::BAS_RSV];
          nxt_q.ctrl4[port_phy_pkg::C4_TXDIS] = view_wdata[port_phy_pkg::BAS_TXDIS];
          nxt_q.an_pulse = view_wdata[port_phy_pkg::BAS_ANRST];
        end
        port_phy_pkg::VIEW_ADV:
        begin
          nxt_q.ctrl4[port_phy_pkg::C4_ADV_HI] = view_wdata[port_phy_pkg::ADV_PAUSE];
          nxt_q.ctrl4[3:0] = view_wdata[port_phy_pkg::ADV_LO + 3:port_phy_pkg::ADV_LO];
        end
        port_phy_pkg::VIEW_PHYCTRL:
        begin
          nxt_q.flink = view_wdata[port_phy_pkg::PCT_FLINK];
          nxt_q.rloop = view_wdata[port_phy_pkg::PCT_RLOOP];
        end
        default:
        begin
        end
      endcase
    end

    // A finished test latches the PHY's results and frees the start bit.
    if (q_ff.cdt == port_phy_pkg::CDT_RUN && cdt_done)
    begin
      nxt_q.cdt = port_phy_pkg::CDT_IDLE;
      nxt_q.outcome = cdt_outcome_in;
      nxt_q.near_short = cdt_short_in;
      nxt_q.fault = cdt_count_in;
    end

    // The host port is applied last so it wins over a same-cycle view write.
    if (reg_wr)
    begin
      unique case (reg_addr)
        port_phy_pkg::ADDR_EGRESS:
        begin
          merged = q_ff.egress;
          if (reg_be[1])
            merged[15:8] = reg_wdata[15:8];
          if (reg_be[0])
            merged[7:0] = reg_wdata[7:0];
          nxt_q.egress = merged;
        end
        port_phy_pkg::ADDR_CABLE:
        begin
          merged = cable_word;
          if (reg_be[1])
            merged[15:8] = reg_wdata[15:8];
          nxt_q.flink = merged[port_phy_pkg::CAB_FLINK];
          nxt_q.rsv10 = merged[port_phy_pkg::CAB_RSV10];
          nxt_q.rloop = merged[port_phy_pkg::CAB_RLOOP];
          // A start request during a running test is ignored.
          if (reg_be[1] && reg_wdata[port_phy_pkg::CAB_START]
              && q_ff.cdt == port_phy_pkg::CDT_IDLE)
            nxt_q.cdt = port_phy_pkg::CDT_RUN;
        end
        port_phy_pkg::ADDR_CTRL4:
        begin
          merged = nxt_q.ctrl4;
          if (reg_be[1])
            merged[15:8] = reg_wdata[15:8];
          if (reg_be[0])
            merged[7:0] = reg_wdata[7:0];
          nxt_q.ctrl4 = merged;
          nxt_q.an_pulse = reg_be[1] & reg_wdata[port_phy_pkg::C4_ANRST];
        end
        default:
        begin
        end
      endcase
    end
    nxt_q.ctrl4[port_phy_pkg::C4_ANRST] = nxt_q.an_pulse;

    // Resolved link mode: forced values apply when negotiation is off or failed.
    if (q_ff.ctrl4[port_phy_pkg::C4_ANEN] && an_good)
    begin
      nxt_q.spd100 = an_speed_100;
      nxt_q.fdup = an_full_dup;
    end
    else
    begin
      nxt_q.spd100 = q_ff.ctrl4[port_phy_pkg::C4_FSPD];
      nxt_q.fdup = q_ff.ctrl4[port_phy_pkg::C4_FDUP];
    end

    if (reg_rd)
    begin
      unique case (reg_addr)
        port_phy_pkg::ADDR_EGRESS: nxt_q.rdata = q_ff.egress;
        port_phy_pkg::ADDR_CABLE: nxt_q.rdata = cable_word;
        port_phy_pkg::ADDR_CTRL4: nxt_q.rdata = q_ff.ctrl4;
        default: nxt_q.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q_ff <= '0;
      q_ff.egress <= port_phy_pkg::EGRESS_RST;
      q_ff.cdt <= port_phy_pkg::CDT_IDLE;
      q_ff.rsv10 <= port_phy_pkg::CABLE_RSV10_RST;
      q_ff.ctrl4 <= port_phy_pkg::CTRL4_RST;
      q_ff.spd100 <= 1'b1;
      q_ff.fdup <= 1'b1;
    end
    else
      q_ff <= nxt_q;
  end

  assign reg_rdata = q_ff.rdata;
  assign cdt_req = (q_ff.cdt == port_phy_pkg::CDT_RUN);
  assign force_link = q_ff.flink;
  assign remote_loop = q_ff.rloop;
  assign tx_disable = q_ff.ctrl4[port_phy_pkg::C4_TXDIS];
  assign an_restart = q_ff.an_pulse;
  assign power_down = q_ff.ctrl4[port_phy_pkg::C4_PWRDN];
  assign mdix_auto_disable = q_ff.ctrl4[port_phy_pkg::C4_MDIXDIS];
  assign force_mdix = q_ff.ctrl4[port_phy_pkg::C4_MDIXDIS]
                      & q_ff.ctrl4[port_phy_pkg::C4_FMDIX];
  assign far_end_loop = q_ff.ctrl4[port_phy_pkg::C4_FARLOOP];
  assign an_enable = q_ff.ctrl4[port_phy_pkg::C4_ANEN];
  assign adv_caps = q_ff.ctrl4[port_phy_pkg::C4_ADV_HI:0];
  assign link_speed_100 = q_ff.spd100;
  assign link_full_dup = q_ff.fdup;

  rate_code_decode prio3_dec (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(q_ff.egress[14:8]),
    .speed_100(q_ff.spd100),
    .rate_kbps(prio3_rate_kbps),
    .unlimited(prio3_unlimited)
  );

  rate_code_decode prio2_dec (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(q_ff.egress[6:0]),
    .speed_100(q_ff.spd100),
    .rate_kbps(prio2_rate_kbps),
    .unlimited(prio2_unlimited)
  );

  AST_EGR_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == 12'h07A && reg_be == 2'h3)
    ##1 !reg_wr ##1 (reg_rd && reg_addr == 12'h07A && !reg_wr)
    |=> (reg_rdata == $past(reg_wdata, 3)))
    else $error("Egress rate word did not read back as written.");

  AST_CDT_START: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == 12'h07C && reg_be[1] && reg_wdata[12] && !cdt_req)
    |=> cdt_req)
    else $error("Cable test did not start on write of one.");

  AST_CDT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    (cdt_req && cdt_done) |=> !cdt_req)
    else $error("Cable test start bit did not clear after done.");

  AST_CABLE_TEST_OUTCOME: assert property (@(posedge clk) disable iff (sys_rst)
    (cdt_req && cdt_done && !reg_wr) ##1 !reg_wr
    ##1 (reg_rd && reg_addr == 12'h07C && !reg_wr)
    |=> (reg_rdata[14:13] == $past(cdt_outcome_in, 3)
         && reg_rdata[15] == $past(cdt_short_in, 3)
         && reg_rdata[8:0] == $past(cdt_count_in, 3) && !reg_rdata[12]))
    else $error("Cable test results not reported.");

  AST_AN_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == 12'h07E && reg_be[1] && reg_wdata[13])
    |=> an_restart ##1 (!an_restart || $past(reg_wr) || $past(view_wr)))
    else $error("Negotiation restart is not a self-clearing pulse.");

  AST_MDIX: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == 12'h07E && reg_be[1])
    |=> (force_mdix == ($past(reg_wdata[10]) & $past(reg_wdata[9]))))
    else $error("Forced crossover does not follow its enable.");

  AST_FORCED_SPEED: assert property (@(posedge clk) disable iff (sys_rst)
    !an_enable |=> (link_speed_100 == $past(q_ff.ctrl4[6])
                    && link_full_dup == $past(q_ff.ctrl4[5])))
    else $error("Forced speed or duplex not applied.");

  AST_ALIAS_TXDIS: assert property (@(posedge clk) disable iff (sys_rst)
    (view_wr && view_sel == 2'h0 && !reg_wr)
    |=> (tx_disable == $past(view_wdata[1]) && power_down == $past(view_wdata[11])))
    else $error("Alias view write did not reach shared storage.");

  AST_RESET_VALUES: assert property (@(posedge clk)
    $fell(sys_rst) |-> (adv_caps == 5'h1F && an_enable && !an_restart && !cdt_req))
    else $error("Control word reset values wrong.");
endmodule : port_phy_control_regs
`default_nettype wire

//--- port_phy_control_regs_tb.sv
// Self-checking testbench for the port PHY register bank.
`timescale 1ns/10ps
`default_nettype none
module port_phy_control_regs_tb;
  logic clk;
  logic sys_rst;
  logic [11:0] reg_addr;
  logic [1:0] reg_be;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic view_wr;
  logic [1:0] view_sel;
  logic [15:0] view_wdata;
  logic [15:0] basic_view;
  logic [15:0] adv_view;
  logic [15:0] phyctrl_view;
  logic cdt_req;
  logic cdt_done;
  logic [1:0] cdt_outcome_in;
  logic cdt_short_in;
  logic [8:0] cdt_count_in;
  logic force_link, remote_loop, tx_disable, an_restart, power_down;
  logic mdix_auto_disable, force_mdix, far_end_loop, an_enable;
  logic [4:0] adv_caps;
  logic an_good, an_speed_100, an_full_dup;
  logic link_speed_100, link_full_dup;
  logic [16:0] prio3_rate_kbps, prio2_rate_kbps;
  logic prio3_unlimited, prio2_unlimited;
  int err_count;
  int checks;
  logic [15:0] rd_val;

  port_phy_control_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .view_wr(view_wr), .view_sel(view_sel), .view_wdata(view_wdata), .basic_view(basic_view),
    .adv_view(adv_view), .phyctrl_view(phyctrl_view), .cdt_req(cdt_req), .cdt_done(cdt_done),
    .cdt_outcome_in(cdt_outcome_in), .cdt_short_in(cdt_short_in), .cdt_count_in(cdt_count_in),
    .force_link(force_link), .remote_loop(remote_loop), .tx_disable(tx_disable),
    .an_restart(an_restart), .power_down(power_down), .mdix_auto_disable(mdix_auto_disable),
    .force_mdix(force_mdix), .far_end_loop(far_end_loop), .an_enable(an_enable),
    .adv_caps(adv_caps), .an_good(an_good), .an_speed_100(an_speed_100),
    .an_full_dup(an_full_dup), .link_speed_100(link_speed_100), .link_full_dup(link_full_dup),
    .prio3_rate_kbps(prio3_rate_kbps), .prio3_unlimited(prio3_unlimited),
    .prio2_rate_kbps(prio2_rate_kbps), .prio2_unlimited(prio2_unlimited));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Writes are sampled at the edge after the strobe goes up.
  task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic vw(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    #1 view_wr = 1'b1;
    view_sel = s;
    view_wdata = d;
    @(posedge clk);
    #1 view_wr = 1'b0;
  endtask : vw

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic test_reset_values;
    rd(port_phy_pkg::ADDR_EGRESS, rd_val);
    chk("egress reset", 17'(rd_val), 17'h00000);
    rd(port_phy_pkg::ADDR_CABLE, rd_val);
    chk("cable reset", 17'(rd_val), 17'h00400);
    rd(port_phy_pkg::ADDR_CTRL4, rd_val);
    chk("ctrl4 reset", 17'(rd_val), 17'h000FF);
    rd(12'h080, rd_val);
    chk("unmapped read", 17'(rd_val), 17'h00000);
    chk("an enable", 17'(an_enable), 17'h00001);
    chk("adv caps", 17'(adv_caps), 17'h0001F);
    chk("prio3 unlimited", 17'(prio3_unlimited), 17'h00001);
    chk("prio2 unlimited", 17'(prio2_unlimited), 17'h00001);
  endtask : test_reset_values

  task automatic test_egress_100;
    wr(port_phy_pkg::ADDR_EGRESS, 2'h3, 16'h6465);
    wr(port_phy_pkg::ADDR_EGRESS, 2'h1, 16'h0A0A);
    rd(port_phy_pkg::ADDR_EGRESS, rd_val);
    chk("egress bytes", 17'(rd_val), 17'h0640A);
    wait_cyc(3);
    chk("prio3 100 code max", prio3_rate_kbps, 17'h186A0);
    chk("prio3 limited", 17'(prio3_unlimited), 17'h00000);
    chk("prio2 100 code 10", prio2_rate_kbps, 17'h02710);
    wr(port_phy_pkg::ADDR_EGRESS, 2'h3, 16'h0073);
    rd(port_phy_pkg::ADDR_EGRESS, rd_val);
    chk("egress word", 17'(rd_val), 17'h00073);
    wait_cyc(3);
    chk("prio3 zero code", 17'(prio3_unlimited), 17'h00001);
    chk("prio2 sub step", prio2_rate_kbps, 17'h003C0);
  endtask : test_egress_100

  task automatic test_cable;
    wr(port_phy_pkg::ADDR_CABLE, 2'h2, 16'hF400);
    chk("cable busy", 17'(cdt_req), 17'h00001);
    rd(port_phy_pkg::ADDR_CABLE, rd_val);
    chk("cable start bit", 17'(rd_val), 17'h01400);
    cdt_outcome_in = 2'h2;
    cdt_short_in = 1'b1;
    cdt_count_in = 9'h1AB;
    @(posedge clk);
    #1 cdt_done = 1'b1;
    @(posedge clk);
    #1 cdt_done = 1'b0;
    chk("cable done", 17'(cdt_req), 17'h00000);
    // Results are read only after the start bit has dropped.
    rd(port_phy_pkg::ADDR_CABLE, rd_val);
    chk("cable result", 17'(rd_val), 17'h0C5AB);
    wr(port_phy_pkg::ADDR_CABLE, 2'h3, 16'h0E00);
    rd(port_phy_pkg::ADDR_CABLE, rd_val);
    chk("cable ctrl", 17'(rd_val), 17'h0CFAB);
    chk("force link", 17'(force_link), 17'h00001);
    chk("remote loop", 17'(remote_loop), 17'h00001);
    chk("phyctrl view", 17'(phyctrl_view[3:0] & 4'hA), 17'h0000A);
  endtask : test_cable

  task automatic test_ctrl4;
    wr(port_phy_pkg::ADDR_CTRL4, 2'h3, 16'h20FF);
    chk("restart pulse", 17'(an_restart), 17'h00001);
    wait_cyc(1);
    chk("restart end", 17'(an_restart), 17'h00000);
    rd(port_phy_pkg::ADDR_CTRL4, rd_val);
    chk("restart clear", 17'(rd_val), 17'h000FF);
    wr(port_phy_pkg::ADDR_CTRL4, 2'h3, 16'h4F1F);
    wait_cyc(1);
    chk("tx disable", 17'(tx_disable), 17'h00001);
    chk("power down", 17'(power_down), 17'h00001);
    chk("mdix auto off", 17'(mdix_auto_disable), 17'h00001);
    chk("force mdix", 17'(force_mdix), 17'h00001);
    chk("far loop", 17'(far_end_loop), 17'h00001);
    chk("forced speed", 17'(link_speed_100), 17'h00000);
    chk("forced duplex", 17'(link_full_dup), 17'h00000);
    chk("basic view", 17'(basic_view & 16'h7B1E), 17'h0481A);
    wr(port_phy_pkg::ADDR_EGRESS, 2'h3, 16'h0A0B);
    wait_cyc(3);
    chk("prio3 10 code", prio3_rate_kbps, 17'h02710);
    chk("prio2 10 over", 17'(prio2_unlimited), 17'h00001);
    wr(port_phy_pkg::ADDR_CTRL4, 2'h2, 16'h0A00);
    chk("mdix not forced", 17'(force_mdix), 17'h00000);
    vw(port_phy_pkg::VIEW_BASIC, 16'h3100);
    rd(port_phy_pkg::ADDR_CTRL4, rd_val);
    chk("alias write", 17'(rd_val), 17'h000FF);
    an_good = 1'b1;
    wait_cyc(2);
    chk("an speed", 17'(link_speed_100), 17'h00000);
    chk("an duplex", 17'(link_full_dup), 17'h00000);
    an_good = 1'b0;
    wait_cyc(2);
    chk("failed an dup", 17'(link_full_dup), 17'h00001);
    // Negotiation stays on, so software drops force-duplex here.
    wr(port_phy_pkg::ADDR_CTRL4, 2'h1, 16'h00C5);
    chk("adv caps cut", 17'(adv_caps), 17'h00005);
    rd(port_phy_pkg::ADDR_CTRL4, rd_val);
    chk("ctrl4 adv", 17'(rd_val), 17'h000C5);
    chk("duplex cleared", 17'(link_full_dup), 17'h00000);
    chk("adv view", 17'(adv_view), 17'h000A0);
    vw(port_phy_pkg::VIEW_ADV, 16'h05E0);
    chk("adv caps alias", 17'(adv_caps), 17'h0001F);
    rd(port_phy_pkg::ADDR_CTRL4, rd_val);
    chk("ctrl4 alias adv", 17'(rd_val), 17'h000DF);
    vw(port_phy_pkg::VIEW_PHYCTRL, 16'h0002);
    chk("alias force link", 17'(force_link), 17'h00000);
    chk("alias remote loop", 17'(remote_loop), 17'h00001);
    rd(port_phy_pkg::ADDR_CABLE, rd_val);
    chk("cable alias", 17'(rd_val), 17'h0C7AB);
  endtask : test_ctrl4

  initial
  begin
    err_count = 0;
    checks = 0;
    sys_rst = 1'b1;
    reg_addr = 12'h000;
    reg_be = 2'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    view_wr = 1'b0;
    view_sel = 2'h3;
    view_wdata = 16'h0000;
    cdt_done = 1'b0;
    cdt_outcome_in = 2'h0;
    cdt_short_in = 1'b0;
    cdt_count_in = 9'h000;
    an_good = 1'b0;
    an_speed_100 = 1'b0;
    an_full_dup = 1'b0;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    test_reset_values();
    test_egress_100();
    test_cable();
    test_ctrl4();
    close_out();
  end

  initial
  begin
    #20000;
    err_count++;
    close_out();
  end
endmodule : port_phy_control_regs_tb
`default_nettype wire
